// file: design/psw_defines.vh
// constants shared by the program status byte execution logic
`ifndef PSW_DEFINES_VH
`define PSW_DEFINES_VH

// register byte offsets on the bus
`define OFS_COMMAND 8'h00
`define OFS_REG_ZERO 8'h04
`define OFS_UPPER 8'h08
`define OFS_LOWER 8'h0C
`define OFS_EXEC_STATUS 8'h10

// command register fields
`define CMD_OPCODE_LSB 0
`define CMD_MASK_LSB 8

// execution status register fields
`define ST_BUSY 0
`define ST_ILLEGAL 1
`define ST_REFUSED 2
`define ST_MCYC_LSB 8
`define ST_PERIODS_LSB 12

// reset values
`define RST_UPPER 8'h00
`define RST_LOWER 8'h00
`define RST_REG_ZERO 8'h00

// opcodes
`define OP_LOAD_UPPER 8'h92
`define OP_LOAD_LOWER 8'h93
`define OP_STORE_UPPER 8'h12
`define OP_STORE_LOWER 8'h13
`define OP_PRESET_UPPER 8'h76
`define OP_PRESET_LOWER 8'h77
`define OP_CLEAR_UPPER 8'h74
`define OP_CLEAR_LOWER 8'h75
`define OP_TEST_UPPER 8'hB4
`define OP_TEST_LOWER 8'hB5

// upper byte positions that can be held as one
`define UPPER_WRITABLE 8'hE7

// condition code positions in the lower byte and its values
`define CODE_HI 7
`define CODE_LO 6
`define CODE_POSITIVE 2'h1
`define CODE_ZERO 2'h0
`define CODE_NEGATIVE 2'h2

// timing: clock periods per machine cycle, machine cycles per class
`define CLK_PER_MCYC 2'h3
`define MCYC_ONE_BYTE 4'h2
`define MCYC_TWO_BYTE 4'h3

`endif

// file: design/psw_alu.v
// result calculation for the ten status byte instructions
`timescale 1ns/10ps
`default_nettype none

module psw_alu (
	// instruction
	input wire [7:0] opcode,
	input wire [7:0] mask,
	// present state
	input wire [7:0] upper_status_byte,
	input wire [7:0] lower_status_byte,
	input wire [7:0] register_zero,
	// results
	output reg legal,
	output reg [3:0] mcycles,
	output reg [7:0] next_upper,
	output reg [7:0] next_lower,
	output reg [7:0] next_reg_zero
);

`include "psw_defines.vh"

// condition code from the sign of a byte
function [1:0] sign_code;
	input [7:0] value;
	begin
		if (value == 8'h00)
			sign_code = `CODE_ZERO;
		else if (value[7])
			sign_code = `CODE_NEGATIVE;
		else
			sign_code = `CODE_POSITIVE;
	end
endfunction

// unselected bits are forced to one so they cannot fail the test
function [1:0] test_code;
	input [7:0] status;
	input [7:0] sel;
	begin
		if ((status | ~sel) == 8'hFF)
			test_code = `CODE_ZERO; // RL13 RL15 RL16
		else
			test_code = `CODE_NEGATIVE;
	end
endfunction

// decode and compute; defaults keep every byte unchanged
always @* begin
	legal = 1'b1;
	mcycles = `MCYC_TWO_BYTE;
	next_upper = upper_status_byte;
	next_lower = lower_status_byte;
	next_reg_zero = register_zero;
	case (opcode)
	`OP_LOAD_UPPER: begin
		mcycles = `MCYC_ONE_BYTE; // RL1
		next_upper = register_zero & `UPPER_WRITABLE; // RL1 RL2
	end
	`OP_LOAD_LOWER: begin
		mcycles = `MCYC_ONE_BYTE; // RL3
		next_lower = register_zero; // RL3 RL4
	end
	`OP_STORE_UPPER: begin
		mcycles = `MCYC_ONE_BYTE; // RL5
		next_reg_zero = upper_status_byte & `UPPER_WRITABLE; // RL5 RL6
		next_lower[`CODE_HI:`CODE_LO] = sign_code(upper_status_byte & `UPPER_WRITABLE); // RL5
	end
	`OP_STORE_LOWER: begin
		mcycles = `MCYC_ONE_BYTE; // RL7
		next_reg_zero = lower_status_byte; // RL7
		next_lower[`CODE_HI:`CODE_LO] = sign_code(lower_status_byte); // RL7
	end
	`OP_PRESET_UPPER: begin
		next_upper = (upper_status_byte | mask) & `UPPER_WRITABLE; // RL8 RL10 RL2
	end
	`OP_PRESET_LOWER: begin
		next_lower = lower_status_byte | mask; // RL9 RL10
	end
	`OP_CLEAR_UPPER: begin
		next_upper = upper_status_byte & ~mask; // RL11 RL10
	end
	`OP_CLEAR_LOWER: begin
		next_lower = lower_status_byte & ~mask; // RL12 RL10
	end
	`OP_TEST_UPPER: begin
		next_lower[`CODE_HI:`CODE_LO] = test_code(upper_status_byte, mask); // RL13
	end
	`OP_TEST_LOWER: begin
		next_lower[`CODE_HI:`CODE_LO] = test_code(lower_status_byte, mask); // RL14
	end
	default: begin
		legal = 1'b0;
		mcycles = 4'h0;
	end
	endcase
end

endmodule

`default_nettype wire

// file: design/psw_exec.v
// program status byte execution unit with an AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none

// Operation
// RL1 - opcode 92 copies register zero into the upper byte in two machine cycles.
// RL2 - upper byte positions four and three always hold zero after any load.
// RL3 - opcode 93 copies register zero into the lower byte in two machine cycles.
// RL4 - loading the lower byte takes the condition code from register zero bits seven and six.
// RL5 - opcode 12 copies the upper byte into register zero and sets the code from its sign.
// RL6 - the stored upper byte always has positions four and three at zero.
// RL7 - opcode 13 copies the lower byte into register zero and sets the code from its sign.
// RL8 - the upper preset sets each upper bit whose mask bit is one, in three cycles; the code keeps positions four and three at zero.
// RL9 - opcode 77 sets each lower bit whose mask bit is one, in three cycles.
// RL10 - preset and clear leave each bit with a zero mask bit unchanged.
// RL11 - opcode 74 clears each upper bit whose mask bit is one, in three cycles.
// RL12 - the lower clear clears each lower bit whose mask bit is one, in three cycles.
// RL13 - opcode B4 gives code 00 when all selected upper bits are one, else 10.
// RL14 - the lower test gives code 00 or 10 likewise and changes nothing else.
// RL15 - a status bit with a zero mask bit has no effect on a test result.
// RL16 - a test with an all-zero mask gives code 00, mask bit n acting on position n.
module psw_exec (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// AHB-Lite slave
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire hready,
	input wire [31:0] hwdata,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	// processor state
	output reg [7:0] upper_status_byte,
	output reg [7:0] lower_status_byte,
	output reg [7:0] register_zero,
	output reg busy,
	output reg exec_done
);

`include "psw_defines.vh"

localparam ST_IDLE = 1'b0;
localparam ST_EXEC = 1'b1;

// address phase capture
reg wr_pending;
reg [7:0] wr_addr;

// instruction in flight
reg state;
reg [7:0] cur_opcode;
reg [7:0] cur_mask;
reg [1:0] period_cnt;
reg [3:0] mcyc_cnt;
reg [3:0] mcyc_need;

// report of the last instruction
reg illegal;
reg refused;
reg [3:0] last_mcyc;
reg [3:0] last_periods;

// results from the calculation block
wire alu_legal;
wire [3:0] alu_mcycles;
wire [7:0] alu_upper;
wire [7:0] alu_lower;
wire [7:0] alu_reg_zero;

// decoded bus events
wire addr_phase;
wire cmd_write;
wire mcyc_tick;
wire commit;
wire [3:0] periods_need;

psw_alu psw_alu_i (
	.opcode(state == ST_EXEC ? cur_opcode : hwdata[`CMD_OPCODE_LSB +: 8]),
	.mask(cur_mask),
	.upper_status_byte(upper_status_byte),
	.lower_status_byte(lower_status_byte),
	.register_zero(register_zero),
	.legal(alu_legal),
	.mcycles(alu_mcycles),
	.next_upper(alu_upper),
	.next_lower(alu_lower),
	.next_reg_zero(alu_reg_zero)
);

// transfer size is not decoded; narrower transfers are handled as words and complete with OKAY
assign addr_phase = hsel && htrans[1] && hready;
assign cmd_write = wr_pending && (wr_addr == `OFS_COMMAND);

// machine cycle enable: one pulse every third clock period
assign mcyc_tick = (state == ST_EXEC) && (period_cnt == `CLK_PER_MCYC - 2'h1);
assign commit = mcyc_tick && (mcyc_cnt == mcyc_need - 4'h1);
assign periods_need = mcyc_need * {2'h0, `CLK_PER_MCYC};

// bus handshake: zero wait states, always OKAY
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		hreadyout <= 1'b0;
		hresp <= 1'b0;
	end else begin
		hreadyout <= 1'b1;
		hresp <= 1'b0;
	end
end

// remember a write address phase for the following data phase
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		wr_pending <= 1'b0;
		wr_addr <= 8'h00;
	end else begin
		wr_pending <= addr_phase && hwrite;
		if (addr_phase)
			wr_addr <= {haddr[7:2], 2'h0};
	end
end

// read data registered at the address phase so it stands in the data phase
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		hrdata <= 32'h00000000;
	end else if (addr_phase && !hwrite) begin
		case ({haddr[7:2], 2'h0})
		`OFS_COMMAND: hrdata <= {16'h0000, cur_mask, cur_opcode};
		`OFS_REG_ZERO: hrdata <= {24'h000000, register_zero};
		`OFS_UPPER: hrdata <= {24'h000000, upper_status_byte};
		`OFS_LOWER: hrdata <= {24'h000000, lower_status_byte};
		`OFS_EXEC_STATUS: hrdata <= {16'h0000, last_periods, last_mcyc,
			5'h00, refused, illegal, busy};
		default: hrdata <= 32'h00000000;
		endcase
	end
end

// sequencer: a command is accepted only while idle
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		state <= ST_IDLE;
		cur_opcode <= 8'h00;
		cur_mask <= 8'h00;
		period_cnt <= 2'h0;
		mcyc_cnt <= 4'h0;
		mcyc_need <= 4'h0;
		busy <= 1'b0;
	end else begin
		case (state)
		ST_IDLE: begin
			period_cnt <= 2'h0;
			mcyc_cnt <= 4'h0;
			if (cmd_write && alu_legal) begin
				cur_opcode <= hwdata[`CMD_OPCODE_LSB +: 8];
				cur_mask <= hwdata[`CMD_MASK_LSB +: 8];
				mcyc_need <= alu_mcycles; // RL1 RL3 RL8 RL11
				state <= ST_EXEC;
				busy <= 1'b1;
			end
		end
		ST_EXEC: begin
			// divider feeding the machine cycle count
			if (mcyc_tick) begin
				period_cnt <= 2'h0;
				mcyc_cnt <= mcyc_cnt + 4'h1;
			end else begin
				period_cnt <= period_cnt + 2'h1;
			end
			if (commit) begin
				state <= ST_IDLE;
				busy <= 1'b0;
			end
		end
		default: begin
			state <= ST_IDLE;
			busy <= 1'b0;
		end
		endcase
	end
end

// architectural bytes: results land on the last clock period of the instruction
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		upper_status_byte <= `RST_UPPER;
		lower_status_byte <= `RST_LOWER;
		register_zero <= `RST_REG_ZERO;
	end else if (commit) begin
		upper_status_byte <= alu_upper; // RL2
		lower_status_byte <= alu_lower; // RL4 RL14
		register_zero <= alu_reg_zero; // RL6
	end else if (wr_pending && state == ST_IDLE) begin
		// software may seed the bytes only between instructions
		case (wr_addr)
		`OFS_REG_ZERO: register_zero <= hwdata[7:0];
		`OFS_UPPER: upper_status_byte <= hwdata[7:0] & `UPPER_WRITABLE; // RL2
		`OFS_LOWER: lower_status_byte <= hwdata[7:0];
		default: register_zero <= register_zero;
		endcase
	end
end

// completion report and error flags
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		exec_done <= 1'b0;
		illegal <= 1'b0;
		refused <= 1'b0;
		last_mcyc <= 4'h0;
		last_periods <= 4'h0;
	end else begin
		exec_done <= commit;
		if (commit) begin
			last_mcyc <= mcyc_need;
			last_periods <= periods_need;
		end
		if (cmd_write && state == ST_IDLE)
			illegal <= !alu_legal;
		// a command or byte write during execution is dropped; set beats clear
		if (wr_pending && state == ST_EXEC && wr_addr != `OFS_EXEC_STATUS)
			refused <= 1'b1;
		else if (wr_pending && wr_addr == `OFS_EXEC_STATUS && hwdata[`ST_REFUSED])
			refused <= 1'b0;
	end
end

endmodule

`default_nettype wire

// file: dv/psw_checker.sv
// assertion checker for the status byte execution unit
`timescale 1ns/10ps
`default_nettype none
`include "psw_defines.vh"
module psw_checker (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// bus requests
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	// processor state
	input wire logic [7:0] upper_status_byte,
	input wire logic [7:0] lower_status_byte,
	input wire logic [7:0] register_zero,
	input wire logic busy,
	input wire logic exec_done
);
	logic cmd_ph;
	logic [7:0] op;
	logic [7:0] m;
	logic [3:0] cnt;
	// keep the accepted command; writes during busy are dropped, so ignore them
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_ph <= 1'b0;
			op <= 8'h00;
			m <= 8'h00;
			cnt <= 4'h0;
		end else begin
			cmd_ph <= hsel && htrans[1] && hready && hwrite && haddr[7:2] == 6'h00;
			if (cmd_ph && !busy) begin
				op <= hwdata[7:0];
				m <= hwdata[15:8];
			end
			cnt <= busy ? cnt + 4'h1 : 4'h0;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_end(o);
		$fell(busy) && op == o;
	endsequence
	property p_hole; upper_status_byte[4:3] == 2'h0; endproperty
	a_hole: assert property (p_hole) else $error("upper hole bits set");
	property p_short; $fell(busy) && !op[2] |-> cnt == 4'h6; endproperty
	a_short: assert property (p_short) else $error("one-byte length wrong");
	property p_long; $fell(busy) && op[2] |-> cnt == 4'h9; endproperty
	a_long: assert property (p_long) else $error("two-byte length wrong");
	property p_ldu; s_end(`OP_LOAD_UPPER) |-> upper_status_byte ==
		($past(register_zero) & `UPPER_WRITABLE); endproperty
	a_ldu: assert property (p_ldu) else $error("upper load wrong");
	property p_ldl; s_end(`OP_LOAD_LOWER) |-> lower_status_byte == $past(register_zero);
	endproperty
	a_ldl: assert property (p_ldl) else $error("lower load wrong");
	property p_stu; s_end(`OP_STORE_UPPER) |-> register_zero == $past(upper_status_byte);
	endproperty
	a_stu: assert property (p_stu) else $error("upper store wrong");
	property p_psl; s_end(`OP_PRESET_LOWER) |->
		lower_status_byte == ($past(lower_status_byte) | m); endproperty
	a_psl: assert property (p_psl) else $error("lower preset wrong");
	property p_clu; s_end(`OP_CLEAR_UPPER) |->
		upper_status_byte == ($past(upper_status_byte) & ~m); endproperty
	a_clu: assert property (p_clu) else $error("upper clear wrong");
	property p_tsu; s_end(`OP_TEST_UPPER) |-> lower_status_byte[7:6] ==
		((($past(upper_status_byte) & m) == m) ? 2'h0 : 2'h2); endproperty
	a_tsu: assert property (p_tsu) else $error("upper test code wrong");
	property p_hold; busy ##1 busy |-> $stable(upper_status_byte) &&
		$stable(lower_status_byte) && $stable(register_zero); endproperty
	a_hold: assert property (p_hold) else $error("state moved mid-instruction");
	property p_done; $fell(busy) |-> ##[0:1] exec_done ##1 !exec_done; endproperty
	a_done: assert property (p_done) else $error("done pulse wrong");
endmodule
bind psw_exec psw_checker psw_checker_i (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
	.upper_status_byte(upper_status_byte), .lower_status_byte(lower_status_byte),
	.register_zero(register_zero), .busy(busy), .exec_done(exec_done));
`default_nettype wire

// file: dv/ahb_host.sv
// bus master model standing in for the instruction sequencer
`timescale 1ns/10ps
`default_nettype none
module ahb_host (
	// clock
	input wire logic core_clk,
	// requests
	output var logic hsel = 1'b0,
	output var logic [7:0] haddr = 8'h00,
	output var logic [1:0] htrans = 2'h0,
	output var logic hwrite = 1'b0,
	output var logic [2:0] hsize = 3'h2,
	output var logic [31:0] hwdata = 32'h0,
	// answers
	input wire logic hready,
	input wire logic [31:0] hrdata
);
	// single word transfer; each phase stands until hready is seen high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge core_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hready !== 1'b1);
		q = hrdata;
		hwdata <= ~d; // a released data line must not keep its value
	endtask
endmodule
`default_nettype wire

// file: dv/psw_exec_tb.sv
// self-checking bench for the status byte execution unit
`timescale 1ns/10ps
`default_nettype none
`include "psw_defines.vh"
module psw_exec_tb;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel, hwrite, hrdy, hresp, busy, exec_done;
	logic [7:0] haddr, up, lo, r0, u, l, r, op, m;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, q;
	logic [23:0] exp_q[$];
	logic [7:0] ops[10] = '{`OP_LOAD_UPPER, `OP_LOAD_LOWER, `OP_STORE_UPPER, `OP_STORE_LOWER,
		`OP_PRESET_UPPER, `OP_PRESET_LOWER, `OP_CLEAR_UPPER, `OP_CLEAR_LOWER,
		`OP_TEST_UPPER, `OP_TEST_LOWER};
	integer seed = 32'h020fc306;
	integer bad_count = 0;
	integer cmp_count = 0;
	always #5 core_clk = ~core_clk;
	ahb_host ahb_host_i (.core_clk(core_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata));
	psw_exec psw_exec_i (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hrdy), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .upper_status_byte(up),
		.lower_status_byte(lo), .register_zero(r0), .busy(busy), .exec_done(exec_done));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	function automatic logic [1:0] sgn(input logic [7:0] v);
		return v == 8'h00 ? `CODE_ZERO : (v[7] ? `CODE_NEGATIVE : `CODE_POSITIVE);
	endfunction
	// each result pulse is matched against the oldest noted expectation
	always @(posedge core_clk) begin
		if (exec_done === 1'b1)
			chk({up, lo, r0}, exp_q.size() ? exp_q.pop_front() : 24'hXXXXXX);
	end
	// runaway guard, far beyond the expected run length
	initial begin
		#400000;
		bad_count++;
		report_and_stop;
	end
	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		for (int t = 0; t < 40; t++) begin
			op = ops[t % 10];
			r = $random(seed);
			u = $random(seed);
			l = $random(seed);
			ahb_host_i.xfer(1'b1, `OFS_REG_ZERO, {24'h0, r}, q);
			ahb_host_i.xfer(1'b1, `OFS_UPPER, {24'h0, u}, q);
			ahb_host_i.xfer(1'b1, `OFS_LOWER, {24'h0, l}, q);
			u = u & `UPPER_WRITABLE;
			ahb_host_i.xfer(1'b0, `OFS_UPPER, 32'h0, q);
			chk(q, {24'h0, u});
			// first pass all-zero masks, second pass masks equal to the tested byte
			m = t < 10 ? 8'h00 : (t < 20 ? (op[0] ? l : u) : $random(seed));
			case (op)
				`OP_LOAD_UPPER: u = r & `UPPER_WRITABLE;
				`OP_LOAD_LOWER: l = r;
				`OP_PRESET_UPPER: u = u | (m & `UPPER_WRITABLE);
				`OP_PRESET_LOWER: l = l | m;
				`OP_CLEAR_UPPER: u = u & ~m;
				`OP_CLEAR_LOWER: l = l & ~m;
				`OP_TEST_UPPER, `OP_TEST_LOWER:
					l[7:6] = (((op[0] ? l : u) & m) == m) ? `CODE_ZERO : `CODE_NEGATIVE;
				default: begin
					r = op[0] ? l : u;
					l[7:6] = sgn(r);
				end
			endcase
			exp_q.push_back({u, l, r});
			ahb_host_i.xfer(1'b1, `OFS_COMMAND, {16'h0, m, op}, q);
			// lands while busy, so it must be dropped and flagged
			ahb_host_i.xfer(1'b1, `OFS_REG_ZERO, {24'h0, ~r}, q);
			// still mid-instruction here: busy up, bus ready and OKAY
			chk({hresp, hrdy, busy}, 3'h3);
			for (int k = 0; k < 20; k++) begin
				ahb_host_i.xfer(1'b0, `OFS_EXEC_STATUS, 32'h0, q);
				if (q[0] === 1'b0)
					break;
			end
			chk(q[15:0], {op[2] ? 8'h93 : 8'h62, 8'h04});
			ahb_host_i.xfer(1'b1, `OFS_EXEC_STATUS, 32'h4, q);
			$display("test %0d opcode %h done", t, op);
		end
		// unknown opcode starts nothing; unmapped place reads zero
		ahb_host_i.xfer(1'b1, `OFS_COMMAND, 32'hFF, q);
		ahb_host_i.xfer(1'b0, `OFS_EXEC_STATUS, 32'h0, q);
		chk(q[1:0], 2'h2);
		ahb_host_i.xfer(1'b0, 8'h14, 32'h0, q);
		chk(q, 32'h0);
		repeat (20) @(posedge core_clk);
		chk(exp_q.size(), 0);
		$display("test illegal and unmapped done");
		report_and_stop;
	end
endmodule
`default_nettype wire
